// file: src/ssm_ctrl.sv
// Purpose: external safety controller end of the safe-stop link
// Assumes: monitor output used only as failure feedback
// Notes: self-test walks the four channel combinations after reset
`default_nettype none
module ssm_ctrl
   import ssm_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = CHK_SETTLE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   ssm_link_if.ctrl link,
   input wire logic guard_closed,
   input wire logic fail_clear,
   output logic run_enable,
   output logic failure
);
   ssm_ctl_state_t st_r, st_nxt;
   logic [1:0] ch_r, ch_nxt, step_r, step_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic fail_r, fail_nxt;
   logic run_r, run_nxt;
   logic expect_mon;
   assign expect_mon = (ch_r == 2'h0);

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      ch_nxt = ch_r;
      step_nxt = step_r;
      cnt_nxt = cnt_r;
      fail_nxt = fail_r;
      case (st_r)
         SSM_SAFE: begin
            ch_nxt = 2'h0;
            step_nxt = 2'h0;
            cnt_nxt = '0;
            st_nxt = SSM_CHECK;
         end
         SSM_CHECK: begin
            // settle each combination, then compare the feedback
            if (cnt_r >= CNT_W'(SETTLE_CYCLES - 1)) begin
               cnt_nxt = '0;
               if (link.stop_monitor_out != expect_mon) begin
                  st_nxt = SSM_FAIL; // [RULE8]
                  ch_nxt = 2'h0;
               end else if (step_r == 2'h3) begin
                  ch_nxt = 2'h0;
                  st_nxt = SSM_ARMED;
               end else begin
                  step_nxt = step_r + 2'h1;
                  ch_nxt = step_r + 2'h1;
               end
            end else begin
               cnt_nxt = cnt_r + CNT_W'(1);
            end
         end
         SSM_ARMED: begin
            ch_nxt = 2'h0;
            if (guard_closed) begin
               if (link.stop_monitor_out) begin
                  ch_nxt = 2'h3; // [RULE3] [RULE7]
                  st_nxt = SSM_RUN;
               end else begin
                  st_nxt = SSM_FAIL; // [RULE4]
               end
            end
         end
         SSM_RUN: begin
            if (!guard_closed) begin
               ch_nxt = 2'h0;
               cnt_nxt = '0;
               st_nxt = SSM_ARMED;
            end
         end
         SSM_FAIL: begin
            ch_nxt = 2'h0; // [RULE4]
            fail_nxt = 1'h1;
            if (fail_clear && !guard_closed) begin
               fail_nxt = 1'h0;
               st_nxt = SSM_SAFE;
            end
         end
         default: begin
            st_nxt = SSM_FAIL;
            ch_nxt = 2'h0;
         end
      endcase
      if (rst) begin
         st_nxt = SSM_SAFE;
         ch_nxt = 2'h0;
         step_nxt = 2'h0;
         cnt_nxt = '0;
         fail_nxt = 1'h0;
      end
      // registered copy of the state decode keeps the output glitch free
      run_nxt = (st_nxt == SSM_RUN);
   end
   always_ff @(posedge clk) begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      fail_r <= fail_nxt;
      run_r <= run_nxt;
   end

   // monitor feeds diagnosis only, never the run decision by itself [RULE9]
   assign link.safe_stop_in_a = ch_r[0];
   assign link.safe_stop_in_b = ch_r[1];
   assign run_enable = run_r;
   assign failure = fail_r;
endmodule : ssm_ctrl
`default_nettype wire

// file: src/ssm_drive.sv
// Purpose: drive side of the hardwired safe stop and its monitor output
// Assumes: channels asynchronous at the pins, one 40 MHz clock
// Notes: alarm is a diagnostic only; the safe state never depends on it
`default_nettype none
module ssm_drive
   import ssm_pkg::*;
#(
   parameter int unsigned FILT_CYCLES = FILT_CYC,
   parameter int unsigned MISMATCH_CYCLES = MISMATCH_CYC
) (
   input wire logic clk,
   input wire logic rst,
   ssm_link_if.drive link,
   input wire logic safety_device_fitted,
   input wire logic drive_request,
   output logic motor_power_en,
   output logic safe_stop_ind,
   output logic channel_mismatch_alarm
);
   ////////////////////////////////////////////////////////////////
   // two-stage synchronisers; stage one is read only by stage two
   logic [1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
   always_comb begin
      sync1_nxt = {link.safe_stop_in_b, link.safe_stop_in_a}; // [RULE13]
      sync2_nxt = sync1_r;
      if (rst) begin
         sync1_nxt = 2'h0;
         sync2_nxt = 2'h0;
      end
   end
   always_ff @(posedge clk) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
   end

   ////////////////////////////////////////////////////////////////
   // off filter: on is taken at once, off only once it lasts
   logic [1:0] filt_r, filt_nxt;
   logic [CNT_W-1:0] fcnt_r [2];
   logic [CNT_W-1:0] fcnt_nxt [2];
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         filt_nxt[i] = filt_r[i];
         fcnt_nxt[i] = '0;
         if (sync2_r[i] == CH_ON) begin
            filt_nxt[i] = CH_ON;
         end else if (filt_r[i] == CH_ON) begin
            if (fcnt_r[i] >= CNT_W'(FILT_CYCLES - 1)) begin
               filt_nxt[i] = CH_OFF; // [RULE11]
            end else begin
               fcnt_nxt[i] = fcnt_r[i] + CNT_W'(1);
            end
         end
         if (rst) begin
            filt_nxt[i] = CH_OFF;
            fcnt_nxt[i] = '0;
         end
      end
   end
   always_ff @(posedge clk) begin
      filt_r <= filt_nxt;
      fcnt_r <= fcnt_nxt;
   end

   ////////////////////////////////////////////////////////////////
   // mismatch timer: only one channel off for too long
   logic [CNT_W-1:0] mcnt_r, mcnt_nxt;
   logic alarm_r, alarm_nxt;
   always_comb begin
      mcnt_nxt = '0;
      alarm_nxt = alarm_r;
      if (filt_r[0] != filt_r[1]) begin
         if (mcnt_r >= CNT_W'(MISMATCH_CYCLES - 1)) begin
            alarm_nxt = 1'h1; // [RULE12]
            mcnt_nxt = mcnt_r;
         end else begin
            mcnt_nxt = mcnt_r + CNT_W'(1);
         end
      end
      if (rst) begin
         mcnt_nxt = '0;
         alarm_nxt = 1'h0;
      end
   end
   always_ff @(posedge clk) begin
      mcnt_r <= mcnt_nxt;
      alarm_r <= alarm_nxt;
   end

   ////////////////////////////////////////////////////////////////
   // outputs, one cycle after the filtered levels (well under 8 ms)
   logic both_off, any_off;
   logic mon_r, mon_nxt, pwr_r, pwr_nxt, ind_r, ind_nxt;
   assign both_off = (filt_r == 2'h0);
   assign any_off = (filt_r != 2'h3);
   always_comb begin
      mon_nxt = both_off; // [RULE1] [RULE2]
      // drive needs both channels on and a fitted safety device
      pwr_nxt = drive_request && !any_off // [RULE10]
         && safety_device_fitted; // [RULE6]
      ind_nxt = any_off || !safety_device_fitted; // [RULE5] [RULE6]
      if (rst) begin
         mon_nxt = 1'h0;
         pwr_nxt = 1'h0;
         ind_nxt = 1'h1;
      end
   end
   always_ff @(posedge clk) begin
      mon_r <= mon_nxt;
      pwr_r <= pwr_nxt;
      ind_r <= ind_nxt;
   end

   assign link.stop_monitor_out = mon_r;
   assign motor_power_en = pwr_r;
   assign safe_stop_ind = ind_r;
   assign channel_mismatch_alarm = alarm_r;
endmodule : ssm_drive
`default_nettype wire

// file: src/ssm_link_if.sv
// Purpose: wires between drive safe-stop end and safety controller end
// Assumes: one clock, all levels synchronous to it
// Notes: channels driven by controller, monitor driven by drive
`default_nettype none
interface ssm_link_if;
   logic safe_stop_in_a;
   logic safe_stop_in_b;
   logic stop_monitor_out;
   modport drive (
      input safe_stop_in_a,
      input safe_stop_in_b,
      output stop_monitor_out
   );
   modport ctrl (
      output safe_stop_in_a,
      output safe_stop_in_b,
      input stop_monitor_out
   );
endinterface : ssm_link_if
`default_nettype wire

// file: src/ssm_pkg.sv
// Purpose: shared constants and types for the safe-stop monitor pair
// Assumes: 40 MHz control clock, synchronous active-high reset
// Notes: channel levels are 1 = on (current flows), 0 = off
//
// Notes on behaviour
// RULE1: monitor out only when both channels off
// RULE2: monitor asserts within 8 ms when healthy
// RULE3: controller re-enables only on feedback, guard closed
// RULE4: no feedback at guard close: stay off, fail
// RULE5: both off: show safe-stop, no motor drive
// RULE6: no safety device fitted: no current, indication
// RULE7: host must monitor the stop monitor output
// RULE8: controller checks monitor against four combinations
// RULE9: monitor output used for failure monitoring only
// RULE10: both off: cut motor power within 8 ms
// RULE11: ignore off pulses of 0.5 ms or less
// RULE12: single channel off over 10 s: mismatch alarm
// RULE13: synchronise both inputs before filtering
`default_nettype none
package ssm_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned OFF_GLITCH_US = 500;
   localparam int unsigned STOP_LIMIT_US = 8000;
   localparam int unsigned MISMATCH_S = 10;
   // filter must accept an off level only after it outlasts the glitch
   localparam int unsigned FILT_CYC =
      (OFF_GLITCH_US * (CLK_HZ / 1000000)) + 1;
   localparam int unsigned STOP_LIMIT_CYC =
      STOP_LIMIT_US * (CLK_HZ / 1000000);
   localparam int unsigned MISMATCH_CYC = MISMATCH_S * CLK_HZ;
   localparam int unsigned CHK_SETTLE_CYC = STOP_LIMIT_CYC + FILT_CYC;
   localparam int unsigned CNT_W = 32;
   localparam logic CH_ON = 1'h1;
   localparam logic CH_OFF = 1'h0;

   typedef enum logic [4:0] {
      SSM_SAFE    = 5'h01,
      SSM_CHECK   = 5'h02,
      SSM_ARMED   = 5'h04,
      SSM_RUN     = 5'h08,
      SSM_FAIL    = 5'h10
   } ssm_ctl_state_t;
endpackage : ssm_pkg
`default_nettype wire

// file: tb/safety_stop_monitor_bench.sv
// Purpose: self-checking bench for the drive and controller pair
// Assumes: short filter and settle counts keep the run brief
// Notes: a stuck channel is imitated by closing the guard too early
`default_nettype none
module safety_stop_monitor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic fitted = 1'h1;
   logic req = 1'h1;
   logic guard = 1'h0;
   logic clr = 1'h0;
   logic power, ind, alarm, run_en, fail;
   int miscompares = 0;
   int check_count = 0;
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   ssm_link_if link ();
   ssm_drive #(.FILT_CYCLES(4), .MISMATCH_CYCLES(50)) ssm_drive_i (
      .clk(clk), .rst(rst), .link(link), .safety_device_fitted(fitted),
      .drive_request(req), .motor_power_en(power), .safe_stop_ind(ind),
      .channel_mismatch_alarm(alarm));
   ssm_ctrl #(.SETTLE_CYCLES(12)) ssm_ctrl_i (.clk(clk), .rst(rst),
      .link(link), .guard_closed(guard), .fail_clear(clr),
      .run_enable(run_en), .failure(fail));
   ssm_link_properties ssm_link_properties_i (.clk(clk), .rst(rst),
      .safe_stop_in_a(link.safe_stop_in_a),
      .safe_stop_in_b(link.safe_stop_in_b),
      .stop_monitor_out(link.stop_monitor_out));
   ////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle
   // order: alarm, run, failure, power, indication, monitor
   task automatic expect_out(input logic [5:0] exp);
      logic [5:0] got;
      got = {alarm, run_en, fail, power, ind, link.stop_monitor_out};
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t outputs %b expected %b", $time, got, exp);
      end
   endtask : expect_out
   task automatic wait_run;
      for (int i = 0; i < 60 && run_en !== 1'h1; i++) @(negedge clk);
      if (run_en !== 1'h1) begin
         miscompares++;
         $display("BAD %0t controller never started", $time);
         wrap_up();
      end
   endtask : wait_run
   ////////////////////////////////////////////////////////////////////
   initial begin
      settle(3);
      rst = 1'h0;
      settle(80);
      expect_out(6'h03);
      guard = 1'h1;
      wait_run();
      settle(10);
      expect_out(6'h14);
      fitted = 1'h0;
      settle(8);
      expect_out(6'h12);
      fitted = 1'h1;
      settle(8);
      guard = 1'h0;
      settle(14);
      expect_out(6'h03);
      guard = 1'h1;
      settle(30);
      // reclosing before feedback returns looks like a stuck channel
      guard = 1'h0;
      settle(2);
      guard = 1'h1;
      settle(30);
      expect_out(6'h0B);
      guard = 1'h0;
      settle(9);
      clr = 1'h1;
      settle(2);
      clr = 1'h0;
      settle(80);
      expect_out(6'h03);
      wrap_up();
   end
endmodule : safety_stop_monitor_bench
`default_nettype wire

// file: tb/ssm_link_properties.sv
// Purpose: wire-level checks of the safe-stop link
// Assumes: drive filter of 4 cycles, controller settle of 12
// Notes: windows allow two sync flops plus the filter
`default_nettype none
module ssm_link_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic safe_stop_in_a,
   input wire logic safe_stop_in_b,
   input wire logic stop_monitor_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic a_w = safe_stop_in_a;
   wire logic b_w = safe_stop_in_b;
   wire logic on_w = a_w | b_w;
   wire logic both_w = a_w & b_w;
   wire logic mon_w = stop_monitor_out;
   // history from before reset is unknown; age gates the deep look-back
   logic [2:0] age_r, age_nxt;
   always_comb begin
      age_nxt = age_r;
      if (age_r != 3'h7) begin
         age_nxt = age_r + 3'h1;
      end
      if (rst) begin
         age_nxt = 3'h0;
      end
   end
   always_ff @(posedge clk) begin
      age_r <= age_nxt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////
   off_only_a: assert property (on_w [*6] |-> !mon_w)
      else $error("monitor set while a channel is on");
   mon_cause_a: assert property
      (mon_w && (age_r == 3'h7) |-> !$past(on_w, 5))
      else $error("monitor set without earlier off channels");
   stop_limit_a: assert property
      (!on_w [*8] ##1 !on_w [*4] |-> mon_w)
      else $error("monitor late after both channels off");
   rearm_gate_a: assert property
      ($rose(both_w) && !$past(on_w) |-> $past(mon_w))
      else $error("channels enabled without feedback");
   no_blind_a: assert property (!mon_w && !on_w |=> !both_w)
      else $error("start despite missing feedback");
   step_one_a: assert property ($rose(a_w) && !b_w |-> !$past(b_w))
      else $error("self-test step order broken");
   step_two_a: assert property ($rose(b_w) && !a_w |-> $past(a_w))
      else $error("self-test second step out of order");
   steady_steps_a: assert property
      ($changed({a_w, b_w}) |=> $stable({a_w, b_w}) [*8])
      else $error("channel pattern held too briefly");
   // main scenarios: feedback seen, a start, the second self-test step
   cover property ($rose(mon_w));
   cover property ($rose(both_w) && !$past(on_w));
   cover property ($rose(b_w) && !a_w);
endmodule : ssm_link_properties
`default_nettype wire
